// ==== shared/nbd_defines.svh ====
// opcodes, timing figures and derived cycle counts for the flash host
`ifndef NBD_DEFINES_SVH
`define NBD_DEFINES_SVH

`define NBD_OPC_READ 8'h00
`define NBD_OPC_READ_GO 8'h30
`define NBD_OPC_PROG 8'h80
`define NBD_OPC_PROG_GO 8'h10
`define NBD_OPC_ERASE 8'h60
`define NBD_OPC_ERASE_GO 8'hD0
`define NBD_OPC_ERASE_QUEUE 8'hD1
`define NBD_OPC_STATUS 8'h70

`define NBD_WAIT_ERASE 8'h00
`define NBD_WAIT_PLANE 8'h01
`define NBD_WAIT_PROG 8'h02
`define NBD_WAIT_READ 8'h03

`define NBD_PARTIAL_PROGRAM_LIMIT 3'h4

`define NBD_CLK_MHZ 40
`define NBD_CLK_PERIOD_NS 25
`define NBD_T_WB_NS 100
`define NBD_T_WW_NS 100
`define NBD_T_WHR_NS 60
`define NBD_T_REA_NS 16
`define NBD_PAGE_PROGRAM_TIME_MAX_US 600
`define NBD_BLOCK_ERASE_TIME_MAX_US 3500
`define NBD_ARRAY_READ_TIME_MAX_US 70
`define NBD_PLANE_QUEUE_BUSY_TIME_MAX_US 1

`define NBD_CEIL_CYC(ns) (((ns) + `NBD_CLK_PERIOD_NS - 1) / `NBD_CLK_PERIOD_NS)
// two extra cycles cover the ready/busy and data synchronisers
`define NBD_WB_CYC (`NBD_CEIL_CYC(`NBD_T_WB_NS) + 2)
`define NBD_WW_CYC `NBD_CEIL_CYC(`NBD_T_WW_NS)
`define NBD_WHR_CYC `NBD_CEIL_CYC(`NBD_T_WHR_NS)
`define NBD_RE_LOW_CYC (`NBD_CEIL_CYC(`NBD_T_REA_NS) + 2)
`define NBD_READ_TMO_CYC (`NBD_ARRAY_READ_TIME_MAX_US * `NBD_CLK_MHZ)
`define NBD_PLANE_TMO_CYC (`NBD_PLANE_QUEUE_BUSY_TIME_MAX_US * `NBD_CLK_MHZ)

`endif

// ==== shared/nbd_pkg.sv ====
// types shared by the flash host controller
package nbd_pkg;

    typedef enum logic [2:0] {
        NBD_OP_STATUS,
        NBD_OP_ERASE1,
        NBD_OP_ERASE2,
        NBD_OP_PROG,
        NBD_OP_READ
    } nbd_op_t;

    typedef enum logic [2:0] {
        NBD_K_CMD,
        NBD_K_ADDR,
        NBD_K_DIN,
        NBD_K_WAIT,
        NBD_K_DOUT,
        NBD_K_END
    } nbd_kind_t;

    typedef struct packed {
        nbd_kind_t kind;
        logic [7:0] val;
    } nbd_item_t;

    typedef struct packed {
        nbd_op_t op;
        logic [15:0] col;
        logic [23:0] row;
        logic [23:0] row2;
        logic [15:0] len;
    } nbd_cmd_t;

    typedef struct packed {
        logic timeout;
        logic refused;
        logic [7:0] status;
    } nbd_rsp_t;

endpackage : nbd_pkg

// ==== rtl/nbd_fifo.sv ====
// synchronous valid/ready fifo for program data
module nbd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff <= nxt_cnt;
        end
    end

    // storage needs no reset; occupancy guards every read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

endmodule : nbd_fifo

// ==== rtl/nbd_host.sv ====
// host controller driving the flash pin interface
//
// Overview of operation
// - two-plane erase: 60,addr,D1 then 60,addr,D0
// - command cycle: CE low, CLE high, WE latches
// - address cycle: CE low, ALE high, WE latches
// - data in via WE, out via read strobe
// - at most four partial programs to the last programmed page; an erase or a program to another page restarts the count
`include "nbd_defines.svh"

module nbd_host
    import nbd_pkg::*;
#(
    parameter int PROG_TMO_CYC =
        `NBD_PAGE_PROGRAM_TIME_MAX_US * `NBD_CLK_MHZ,
    parameter int ERASE_TMO_CYC =
        `NBD_BLOCK_ERASE_TIME_MAX_US * `NBD_CLK_MHZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // operation request and result
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nbd_cmd_t cmd,
    output logic rsp_valid,
    output nbd_rsp_t rsp,
    // program data stream
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // read data stream
    output logic rd_valid,
    output logic [7:0] rd_data,
    // flash pins
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic wp_n,
    output logic [7:0] dq_o,
    output logic dq_oe,
    input wire logic [7:0] dq_i,
    input wire logic rb_n
);
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_ITEM, S_WE_LOW, S_WE_HIGH,
        S_WB, S_WAIT_RB, S_GAP, S_RE_LOW, S_END
    } nbd_state_t;

    function automatic nbd_item_t seq_item(nbd_op_t op, logic [3:0] ph,
                                           logic [15:0] col,
                                           logic [23:0] row,
                                           logic [23:0] row2);
        nbd_item_t it;
        it = '{NBD_K_END, 8'h00};
        unique case (op)
            NBD_OP_STATUS: begin
                if (ph == 4'h0) it = '{NBD_K_CMD, `NBD_OPC_STATUS};
                if (ph == 4'h1) it = '{NBD_K_DOUT, 8'h00};
            end
            NBD_OP_ERASE1, NBD_OP_ERASE2: begin
                unique case (ph)
                    4'h0, 4'h6: it = '{NBD_K_CMD, `NBD_OPC_ERASE};
                    4'h1: it = '{NBD_K_ADDR, row[7:0]};
                    4'h2: it = '{NBD_K_ADDR, row[15:8]};
                    4'h3: it = '{NBD_K_ADDR, row[23:16]};
                    4'h4: it = (op == NBD_OP_ERASE2) ?
                        '{NBD_K_CMD, `NBD_OPC_ERASE_QUEUE} :
                        '{NBD_K_CMD, `NBD_OPC_ERASE_GO};
                    4'h5: it = (op == NBD_OP_ERASE2) ?
                        '{NBD_K_WAIT, `NBD_WAIT_PLANE} :
                        '{NBD_K_WAIT, `NBD_WAIT_ERASE};
                    4'h7: it = '{NBD_K_ADDR, row2[7:0]};
                    4'h8: it = '{NBD_K_ADDR, row2[15:8]};
                    4'h9: it = '{NBD_K_ADDR, row2[23:16]};
                    4'hA: it = '{NBD_K_CMD, `NBD_OPC_ERASE_GO};
                    4'hB: it = '{NBD_K_WAIT, `NBD_WAIT_ERASE};
                    4'hC: it = '{NBD_K_CMD, `NBD_OPC_STATUS};
                    4'hD: it = '{NBD_K_DOUT, 8'h00};
                    default: it = '{NBD_K_END, 8'h00};
                endcase
                // a single-plane erase skips the second plane's phases
                if (op == NBD_OP_ERASE1 && ph == 4'h6)
                    it = '{NBD_K_CMD, `NBD_OPC_STATUS};
                if (op == NBD_OP_ERASE1 && ph == 4'h7)
                    it = '{NBD_K_DOUT, 8'h00};
                if (op == NBD_OP_ERASE1 && ph > 4'h7)
                    it = '{NBD_K_END, 8'h00};
            end
            NBD_OP_PROG, NBD_OP_READ: begin
                unique case (ph)
                    4'h0: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_CMD, `NBD_OPC_PROG} :
                        '{NBD_K_CMD, `NBD_OPC_READ};
                    4'h1: it = '{NBD_K_ADDR, col[7:0]};
                    4'h2: it = '{NBD_K_ADDR, col[15:8]};
                    4'h3: it = '{NBD_K_ADDR, row[7:0]};
                    4'h4: it = '{NBD_K_ADDR, row[15:8]};
                    4'h5: it = '{NBD_K_ADDR, row[23:16]};
                    4'h6: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_DIN, 8'h00} :
                        '{NBD_K_CMD, `NBD_OPC_READ_GO};
                    4'h7: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_CMD, `NBD_OPC_PROG_GO} :
                        '{NBD_K_WAIT, `NBD_WAIT_READ};
                    4'h8: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_WAIT, `NBD_WAIT_PROG} :
                        '{NBD_K_DOUT, 8'h00};
                    4'h9: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_CMD, `NBD_OPC_STATUS} :
                        '{NBD_K_END, 8'h00};
                    4'hA: it = (op == NBD_OP_PROG) ?
                        '{NBD_K_DOUT, 8'h00} : '{NBD_K_END, 8'h00};
                    default: it = '{NBD_K_END, 8'h00};
                endcase
            end
            default: it = '{NBD_K_END, 8'h00};
        endcase
        return it;
    endfunction : seq_item

    nbd_state_t state_ff, nxt_state;
    nbd_cmd_t req_ff, nxt_req;
    logic [3:0] ph_ff, nxt_ph;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [17:0] tmr_ff, nxt_tmr;
    logic [23:0] last_row_ff, nxt_last_row;
    logic [2:0] pp_cnt_ff, nxt_pp_cnt;
    logic tmo_ff, nxt_tmo;
    logic ce_n_ff, nxt_ce_n, cle_ff, nxt_cle, ale_ff, nxt_ale;
    logic we_n_ff, nxt_we_n, re_n_ff, nxt_re_n, wp_n_ff, nxt_wp_n;
    logic [7:0] dq_o_ff, nxt_dq_o;
    logic dq_oe_ff, nxt_dq_oe;
    logic rd_valid_ff, nxt_rd_valid;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic rsp_valid_ff, nxt_rsp_valid;
    nbd_rsp_t rsp_ff, nxt_rsp;
    logic rb_meta_ff, rb_sync_ff;
    logic [7:0] dq_meta_ff, dq_sync_ff;
    logic fifo_valid, fifo_ready;
    logic [7:0] fifo_data;
    nbd_item_t it;
    logic [15:0] dout_len;
    logic is_pe;

    nbd_fifo #(.W(8), .DEPTH(8)) u_wr_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    assign cmd_ready = (state_ff == S_IDLE);
    assign it = seq_item(req_ff.op, ph_ff, req_ff.col, req_ff.row,
                         req_ff.row2);
    assign dout_len = (req_ff.op == NBD_OP_READ) ? req_ff.len : 16'h0001;
    assign is_pe = (cmd.op != NBD_OP_STATUS) && (cmd.op != NBD_OP_READ);

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_ph = ph_ff;
        nxt_cnt = cnt_ff;
        nxt_tmr = tmr_ff;
        nxt_last_row = last_row_ff;
        nxt_pp_cnt = pp_cnt_ff;
        nxt_tmo = tmo_ff;
        nxt_ce_n = ce_n_ff;
        nxt_cle = cle_ff;
        nxt_ale = ale_ff;
        nxt_we_n = 1'b1;
        nxt_re_n = 1'b1;
        nxt_wp_n = wp_n_ff;
        nxt_dq_o = dq_o_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_rd_valid = 1'b0;
        nxt_rd_data = rd_data_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp = rsp_ff;
        fifo_ready = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                if (cmd_valid) begin
                    if (cmd.op == NBD_OP_PROG && cmd.row == last_row_ff &&
                        pp_cnt_ff == `NBD_PARTIAL_PROGRAM_LIMIT) begin
                        nxt_rsp_valid = 1'b1;
                        nxt_rsp = '{1'b0, 1'b1, 8'h00};
                    end else begin
                        nxt_req = cmd;
                        nxt_ph = 4'h0;
                        nxt_cnt = 16'h0000;
                        nxt_tmo = 1'b0;
                        nxt_ce_n = 1'b0;
                        // write protect lifted only for program and erase
                        nxt_wp_n = is_pe;
                        nxt_tmr = 18'(`NBD_WW_CYC);
                        nxt_state = S_SETUP;
                        if (cmd.op == NBD_OP_PROG) begin
                            nxt_last_row = cmd.row;
                            nxt_pp_cnt = (cmd.row == last_row_ff) ?
                                pp_cnt_ff + 3'h1 : 3'h1;
                        end else if (is_pe) begin
                            nxt_pp_cnt = 3'h0;
                        end
                    end
                end
            end
            S_SETUP, S_GAP: begin
                if (tmr_ff != '0) begin
                    nxt_tmr = tmr_ff - 18'h00001;
                end else if (state_ff == S_SETUP) begin
                    nxt_state = S_ITEM;
                end else begin
                    nxt_re_n = 1'b0;
                    nxt_tmr = 18'(`NBD_RE_LOW_CYC);
                    nxt_state = S_RE_LOW;
                end
            end
            S_ITEM: begin
                nxt_cle = (it.kind == NBD_K_CMD);
                nxt_ale = (it.kind == NBD_K_ADDR);
                nxt_dq_oe = (it.kind == NBD_K_CMD) ||
                    (it.kind == NBD_K_ADDR) || (it.kind == NBD_K_DIN);
                unique case (it.kind)
                    NBD_K_CMD, NBD_K_ADDR: begin
                        nxt_dq_o = it.val;
                        nxt_state = S_WE_LOW;
                    end
                    NBD_K_DIN: begin
                        if (cnt_ff == req_ff.len) begin
                            nxt_ph = ph_ff + 4'h1;
                            nxt_cnt = 16'h0000;
                        end else if (fifo_valid) begin
                            // an empty fifo stalls the page load here
                            fifo_ready = 1'b1;
                            nxt_dq_o = fifo_data;
                            nxt_cnt = cnt_ff + 16'h0001;
                            nxt_state = S_WE_LOW;
                        end
                    end
                    NBD_K_WAIT: begin
                        nxt_tmr = 18'(`NBD_WB_CYC);
                        nxt_state = S_WB;
                    end
                    NBD_K_DOUT: begin
                        if (cnt_ff == dout_len) begin
                            nxt_ph = ph_ff + 4'h1;
                            nxt_cnt = 16'h0000;
                        end else if (cnt_ff == 16'h0000) begin
                            nxt_tmr = 18'(`NBD_WHR_CYC);
                            nxt_state = S_GAP;
                        end else begin
                            nxt_re_n = 1'b0;
                            nxt_tmr = 18'(`NBD_RE_LOW_CYC);
                            nxt_state = S_RE_LOW;
                        end
                    end
                    NBD_K_END: nxt_state = S_END;
                endcase
            end
            S_WE_LOW: begin
                nxt_we_n = 1'b0;
                nxt_state = S_WE_HIGH;
            end
            S_WE_HIGH: begin
                if (it.kind != NBD_K_DIN) nxt_ph = ph_ff + 4'h1;
                nxt_state = S_ITEM;
            end
            S_WB: begin
                if (tmr_ff != '0) begin
                    nxt_tmr = tmr_ff - 18'h00001;
                end else begin
                    unique case (it.val)
                        `NBD_WAIT_PLANE: nxt_tmr = 18'(`NBD_PLANE_TMO_CYC);
                        `NBD_WAIT_PROG: nxt_tmr = 18'(PROG_TMO_CYC);
                        `NBD_WAIT_READ: nxt_tmr = 18'(`NBD_READ_TMO_CYC);
                        default: nxt_tmr = 18'(ERASE_TMO_CYC);
                    endcase
                    nxt_state = S_WAIT_RB;
                end
            end
            S_WAIT_RB: begin
                // nothing else is issued until ready returns or the wait timer runs out
                if (rb_sync_ff) begin
                    nxt_ph = ph_ff + 4'h1;
                    nxt_state = S_ITEM;
                end else if (tmr_ff == '0) begin
                    nxt_tmo = 1'b1;
                    nxt_state = S_END;
                end else begin
                    nxt_tmr = tmr_ff - 18'h00001;
                end
            end
            S_RE_LOW: begin
                if (tmr_ff != '0) begin
                    nxt_re_n = 1'b0;
                    nxt_tmr = tmr_ff - 18'h00001;
                end else begin
                    nxt_rd_valid = 1'b1;
                    nxt_rd_data = dq_sync_ff;
                    nxt_rsp.status = dq_sync_ff;
                    nxt_cnt = cnt_ff + 16'h0001;
                    nxt_state = S_ITEM;
                end
            end
            S_END: begin
                nxt_ce_n = 1'b1;
                nxt_wp_n = 1'b0;
                nxt_cle = 1'b0;
                nxt_ale = 1'b0;
                nxt_dq_oe = 1'b0;
                nxt_rsp_valid = 1'b1;
                nxt_rsp.timeout = tmo_ff;
                nxt_rsp.refused = 1'b0;
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff <= S_IDLE;
            req_ff <= '0;
            ph_ff <= 4'h0;
            cnt_ff <= 16'h0000;
            tmr_ff <= '0;
            last_row_ff <= 24'h000000;
            pp_cnt_ff <= 3'h0;
            tmo_ff <= 1'b0;
            ce_n_ff <= 1'b1;
            cle_ff <= 1'b0;
            ale_ff <= 1'b0;
            we_n_ff <= 1'b1;
            re_n_ff <= 1'b1;
            wp_n_ff <= 1'b0;
            dq_o_ff <= 8'h00;
            dq_oe_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 8'h00;
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            ph_ff <= nxt_ph;
            cnt_ff <= nxt_cnt;
            tmr_ff <= nxt_tmr;
            last_row_ff <= nxt_last_row;
            pp_cnt_ff <= nxt_pp_cnt;
            tmo_ff <= nxt_tmo;
            ce_n_ff <= nxt_ce_n;
            cle_ff <= nxt_cle;
            ale_ff <= nxt_ale;
            we_n_ff <= nxt_we_n;
            re_n_ff <= nxt_re_n;
            wp_n_ff <= nxt_wp_n;
            dq_o_ff <= nxt_dq_o;
            dq_oe_ff <= nxt_dq_oe;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff <= nxt_rd_data;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_ff <= nxt_rsp;
        end
    end

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rb_meta_ff <= 1'b0;
            rb_sync_ff <= 1'b0;
            dq_meta_ff <= 8'h00;
            dq_sync_ff <= 8'h00;
        end else begin
            rb_meta_ff <= rb_n;
            rb_sync_ff <= rb_meta_ff;
            dq_meta_ff <= dq_i;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    assign ce_n = ce_n_ff;
    assign cle = cle_ff;
    assign ale = ale_ff;
    assign we_n = we_n_ff;
    assign read_strobe_n = re_n_ff;
    assign wp_n = wp_n_ff;
    assign dq_o = dq_o_ff;
    assign dq_oe = dq_oe_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_data = rd_data_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp = rsp_ff;

endmodule : nbd_host

// ==== testbench/nbd_host_monitor.sv ====
// pin and answer assertions for the flash host
module nbd_host_monitor
    import nbd_pkg::*;
#(
    parameter int PROG_TMO_CYC = 24000,
    parameter int ERASE_TMO_CYC = 140000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // answers
    input wire logic rsp_valid,
    input wire nbd_rsp_t rsp,
    // flash pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe,
    input wire logic rb_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wr_cmd(b);
        !we_n && cle && dq_o == b;
    endsequence
    sequence s_queue;
        s_wr_cmd(8'hD1);
    endsequence

    a_cmd_shape: assert property (
        cle |-> !ale && !ce_n && read_strobe_n)
        else $error("command cycle malformed");
    a_addr_shape: assert property (
        ale |-> !cle && !ce_n && read_strobe_n)
        else $error("address cycle malformed");
    a_wp_prog: assert property (
        (!we_n && cle && dq_o inside {8'h80, 8'h10, 8'h60, 8'hD0, 8'hD1})
        |-> wp_n && $past(wp_n, 3))
        else $error("write protect low on program or erase");
    a_din_wp: assert property (
        (!we_n && !cle && !ale) |-> wp_n && dq_oe && !ce_n)
        else $error("data input cycle malformed");
    a_re_quiet: assert property (
        !read_strobe_n |-> !ce_n && !cle && !ale && we_n && !dq_oe)
        else $error("data output cycle malformed");
    a_we_pulse: assert property (
        $fell(we_n) |=> we_n ##1 we_n)
        else $error("write strobe pulse shape wrong");
    a_busy_no_cmd: assert property (
        (!we_n && cle && !rb_n) |-> dq_o == 8'h70)
        else $error("command other than status while busy");
    a_wait_cfm: assert property (
        s_wr_cmd(8'hD0) |=> ##1 !cle [*6])
        else $error("command too soon after erase confirm");
    a_queue_next: assert property (
        s_queue |-> ##[2:90] s_wr_cmd(8'h60))
        else $error("second plane setup missing");
    a_rsp_pulse: assert property (
        rsp_valid |-> ce_n ##1 !rsp_valid)
        else $error("answer pulse wrong");
    a_refuse_quiet: assert property (
        (rsp_valid && rsp.refused) |-> $past(ce_n) && $past(we_n))
        else $error("refused program touched pins");
endmodule : nbd_host_monitor

bind nbd_host nbd_host_monitor #(
    .PROG_TMO_CYC(PROG_TMO_CYC),
    .ERASE_TMO_CYC(ERASE_TMO_CYC)
) i_mon (
    .core_clk(core_clk), .reset_n(reset_n), .rsp_valid(rsp_valid),
    .rsp(rsp), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_o(dq_o),
    .dq_oe(dq_oe), .rb_n(rb_n)
);

// ==== testbench/nbd_flash_model.sv ====
// behavioural flash device answering the host pins
module nbd_flash_model #(
    parameter logic [7:0] STAT = 8'hE0
) (
    // host pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [7:0] dq_o,
    // bench control
    input wire logic slow,
    // device outputs
    output logic [7:0] dq_i,
    output logic rb_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [39:0] hist = '0;
    logic [7:0] rcnt = 8'h00;
    logic [7:0] din_last = 8'h00;
    logic [7:0] ob;
    logic rb = 1'b1;
    logic queued = 1'b0;
    int erased = 0;
    int din_cnt = 0;

    // slow stretches any busy to 20000 ns, past every host timeout except the array read's
    task automatic busy(input int ns);
        fork
            begin
                #50;
                rb = 1'b0;
                #(slow ? 20000 : ns);
                rb = 1'b1;
            end
        join_none
    endtask : busy

    always @(posedge we_n) begin
        if (!ce_n && read_strobe_n && cle && !ale) begin
            hist = {hist[31:0], dq_o};
            rcnt = 8'h00;
            case (dq_o)
                8'h80: din_cnt = 0;
                8'hD1: if (wp_n) begin
                    queued = 1'b1;
                    busy(300);
                end
                8'hD0: if (wp_n) begin
                    erased = queued ? 2 : 1;
                    queued = 1'b0;
                    busy(1000);
                end
                8'h10: if (wp_n) busy(800);
                8'h30: busy(1500);
                default: ;
            endcase
        end else if (!ce_n && read_strobe_n && !cle && !ale && wp_n) begin
            din_cnt++;
            din_last = dq_o;
        end
    end

    always @(posedge read_strobe_n) begin
        if (!ce_n && hist[7:0] != 8'h70) rcnt++;
    end

    assign ob = (hist[7:0] == 8'h70) ? STAT : 8'h30 + rcnt;
    // released bus shows the inverse so stale data never matches
    assign dq_i = (!ce_n && !read_strobe_n) ? ob : ~ob;
    assign rb_n = rb;
endmodule : nbd_flash_model

// ==== testbench/tb_nbd_host.sv ====
// self-checking bench for the flash host controller
module tb_nbd_host
    import nbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] STAT = 8'hE0;
    logic core_clk = 0, reset_n = 0, cmd_valid = 0, wr_valid = 0, slow = 0;
    logic [7:0] wr_data = 8'h00;
    nbd_cmd_t cmd = '0;
    logic cmd_ready, rsp_valid, wr_ready, rd_valid, ce_n, cle, ale, we_n;
    logic read_strobe_n, wp_n, dq_oe, rb_n;
    logic [7:0] rd_data, dq_o, dq_i;
    nbd_rsp_t rsp;
    logic [7:0] q[$];
    int fails = 0, checks_done = 0;

    nbd_host #(.PROG_TMO_CYC(200), .ERASE_TMO_CYC(200)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp(rsp), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i), .rb_n(rb_n));
    nbd_flash_model #(.STAT(STAT)) i_flash (
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_o(dq_o),
        .slow(slow), .dq_i(dq_i), .rb_n(rb_n));

    always #12.5 core_clk = ~core_clk;

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic run(input nbd_op_t o, input logic [23:0] r,
                       input logic [23:0] r2, input logic [15:0] n);
        int i;
        q.delete();
        @(posedge core_clk);
        #1;
        cmd = '{o, 16'h0000, r, r2, n};
        cmd_valid = 1;
        for (i = 0; i < 9 && cmd_ready !== 1'b1; i++) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        cmd_valid = 0;
        for (i = 0; i < 3000; i++) begin
            if (rd_valid === 1'b1) q.push_back(rd_data);
            if (rsp_valid === 1'b1) break;
            @(posedge core_clk);
            #1;
        end
        chk(rsp_valid, 1);
    endtask : run

    task automatic t_status;
        run(NBD_OP_STATUS, 0, 0, 0);
        chk(rsp.status, STAT);
        chk(i_flash.hist[7:0], 8'h70);
    endtask : t_status

    task automatic t_erase2;
        run(NBD_OP_ERASE2, 24'h000040, 24'h000080, 0);
        chk(i_flash.hist, 40'h60D160D070);
        chk(i_flash.erased, 2);
        chk(rsp.timeout, 0);
    endtask : t_erase2

    task automatic t_fill_prog;
        int i;
        wr_valid = 1;
        for (i = 0; i < 8; i++) begin
            wr_data = 8'hA0 + i[7:0];
            @(posedge core_clk);
            #1;
        end
        wr_valid = 0;
        chk(wr_ready, 0);
        run(NBD_OP_PROG, 24'h000005, 0, 8);
        chk(i_flash.din_cnt, 8);
        chk(i_flash.din_last, 8'hA7);
        chk(i_flash.hist[15:0], 16'h1070);
        chk(wr_ready, 1);
    endtask : t_fill_prog

    task automatic t_read;
        int i;
        run(NBD_OP_READ, 24'h000005, 0, 3);
        chk(q.size(), 3);
        for (i = 0; i < 3; i++) chk(q[i], 8'h30 + i[7:0]);
    endtask : t_read

    // four programs to one row are allowed, the fifth is turned away
    task automatic t_limit;
        logic [39:0] h;
        repeat (3) begin
            run(NBD_OP_PROG, 24'h000005, 0, 0);
            chk(rsp.refused, 0);
        end
        h = i_flash.hist;
        run(NBD_OP_PROG, 24'h000005, 0, 0);
        chk(rsp.refused, 1);
        chk(i_flash.hist, h);
    endtask : t_limit

    task automatic t_tmo;
        int i;
        slow = 1;
        run(NBD_OP_PROG, 24'h000009, 0, 0);
        chk(rsp.timeout, 1);
        for (i = 0; i < 1000 && rb_n !== 1'b1; i++) @(posedge core_clk);
        slow = 0;
    endtask : t_tmo

    // single-plane erase must not take the plane-queue path
    task automatic t_erase1;
        run(NBD_OP_ERASE1, 24'h0000C0, 0, 0);
        chk(i_flash.hist[23:0], 24'h60D070);
        chk(i_flash.erased, 1);
        chk(rsp.timeout, 0);
    endtask : t_erase1

    task automatic stop_test;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    initial begin
        #200us;
        fails++;
        stop_test;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        reset_n = 1;
        t_status;
        t_erase2;
        t_fill_prog;
        t_read;
        t_limit;
        t_tmo;
        t_erase1;
        stop_test;
    end
endmodule : tb_nbd_host
